// ===== rtl/cisx_core.v
// six-instruction executor with classic wishbone register slave
//
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "cisx_map.vh"
module cisx_core (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [11:0] wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   output wire        wb_ack_o,
   output wire [12:0] pc_o,
   output wire [7:0]  acc_o,
   output wire [7:0]  status_o,
   output wire [12:0] stack_top_o,
   output wire        wdt_clear_o,
   output wire        wdt_presc_clear_o,
   output wire        busy_o
);

   localparam S_IDLE  = 2'b00;
   localparam S_EXEC  = 2'b01;
   localparam S_JUMP2 = 2'b10;

   reg  [1:0]  state_ff;
   reg  [1:0]  nxt_state;
   reg  [31:0] instr_ff;
   reg  [31:0] nxt_instr;
   reg  [7:0]  status_ff;
   reg  [7:0]  nxt_status;
   reg  [7:0]  acc_ff;
   reg  [7:0]  nxt_acc;
   reg  [12:0] pc_ff;
   reg  [12:0] nxt_pc;
   reg  [4:0]  latch_ff;
   reg  [4:0]  nxt_latch;
   reg  [2:0]  sp_ff;
   reg  [2:0]  nxt_sp;
   reg  [12:0] stack_ff [0:7];
   reg  [12:0] top_ff;
   reg  [12:0] nxt_top;
   reg         push;
   reg  [31:0] dat_ff;
   reg  [31:0] nxt_dat;
   reg         ack_ff;
   reg         nxt_ack;
   reg         wdt_clr_ff;
   reg         nxt_wdt_clr;
   reg         presc_clr_ff;
   reg         nxt_presc_clr;
   reg         busy_ff;
   reg         nxt_busy;
   reg         f_we;
   reg  [7:0]  f_wdata;
   reg  [6:0]  f_waddr;
   reg  [31:0] merged;
   reg  [7:0]  result;
   integer     j;

   wire        req;
   wire        bus_ok;
   wire        file_hit;
   wire [6:0]  bus_index;
   wire [2:0]  op;
   wire        dest;
   wire [6:0]  f_addr;
   wire [10:0] k_imm;
   wire [6:0]  rd_addr;
   wire [7:0]  rd_data;
   wire [31:0] instr_rd;
   wire [31:0] stack_rd;
   wire        stack_hit;
   wire [2:0]  stack_index;
   wire [12:0] entry_rd;
   wire        res_zero;

   // byte-lane merge of a write into an old value
   function [31:0] cisx_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  sel_v;
      integer      i;
      begin
         cisx_merge = old_v;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel_v[i]) begin
               cisx_merge[i*8 +: 8] = new_v[i*8 +: 8];
            end
         end
      end
   endfunction

   assign req       = wb_cyc_i & wb_stb_i & ~ack_ff;
   // bus stalls while an instruction runs
   assign bus_ok    = req & (state_ff == S_IDLE);
   assign file_hit  = (wb_adr_i[11:9] == `CISX_FILE_TAG);
   assign bus_index = wb_adr_i[8:2];
   assign op        = instr_ff[`CISX_OP_HI:`CISX_OP_LO];
   assign dest      = instr_ff[`CISX_DEST_BIT];
   assign f_addr    = instr_ff[`CISX_F_HI:0];
   assign k_imm     = instr_ff[`CISX_K_HI:0];
   assign rd_addr   = (state_ff == S_EXEC) ? f_addr : bus_index;
   assign instr_rd  = {busy_ff, instr_ff[`CISX_BUSY_BIT-1:0]};
   assign stack_rd  = {13'h0000, sp_ff, 3'h0, top_ff};
   assign res_zero  = (result == 8'h00);

   // return stack window, one entry a word
   assign stack_hit   = (wb_adr_i[11:5] == `CISX_STACK_TAG);
   assign stack_index = wb_adr_i[4:2];
   assign entry_rd    = stack_ff[stack_index];

   cisx_regfile u_regfile (
      .clk_i     (clk_i),
      .wr_en_i   (f_we),
      .wr_addr_i (f_waddr),
      .wr_data_i (f_wdata),
      .rd_addr_i (rd_addr),
      .rd_data_o (rd_data)
   );

   // result of the data operations
   always @* begin
      case (op)
         `CISX_OP_INVERT: begin
            result = ~rd_data;
         end
         `CISX_OP_ZERO_F: begin
            result = 8'h00;
         end
         `CISX_OP_MINUS: begin
            result = rd_data - 8'h01;
         end
         `CISX_OP_ZERO_A: begin
            result = 8'h00;
         end
         default: begin
            result = 8'h00;
         end
      endcase
   end

   always @* begin
      nxt_state     = state_ff;
      nxt_instr     = instr_ff;
      nxt_status    = status_ff;
      nxt_acc       = acc_ff;
      nxt_pc        = pc_ff;
      nxt_latch     = latch_ff;
      nxt_sp        = sp_ff;
      nxt_top       = top_ff;
      push          = 1'b0;
      nxt_dat       = dat_ff;
      nxt_ack       = 1'b0;
      nxt_wdt_clr   = 1'b0;
      nxt_presc_clr = 1'b0;
      f_we          = 1'b0;
      f_waddr       = f_addr;
      f_wdata       = 8'h00;
      merged        = 32'h00000000;

      // register slave, answers one cycle after the request
      if (bus_ok) begin
         nxt_ack = 1'b1;
         nxt_dat = 32'h00000000;
         if (file_hit) begin
            nxt_dat = {24'h000000, rd_data};
            if (wb_we_i && wb_sel_i[0]) begin
               f_we    = 1'b1;
               f_waddr = bus_index;
               f_wdata = wb_dat_i[7:0];
            end
         end else if (stack_hit) begin
            nxt_dat = {19'h00000, entry_rd};
         end else begin
            case (wb_adr_i)
               `CISX_ADR_INSTR: begin
                  nxt_dat = instr_rd;
                  if (wb_we_i) begin
                     merged    = cisx_merge(instr_ff, wb_dat_i, wb_sel_i);
                     nxt_instr = merged;
                     if (merged[`CISX_OP_HI:`CISX_OP_LO] != `CISX_OP_NONE) begin
                        nxt_state = S_EXEC;
                     end
                  end
               end
               `CISX_ADR_STATUS: begin
                  nxt_dat = {24'h000000, status_ff};
                  if (wb_we_i) begin
                     merged     = cisx_merge({24'h000000, status_ff}, wb_dat_i, wb_sel_i);
                     nxt_status = merged[7:0];
                  end
               end
               `CISX_ADR_ACC: begin
                  nxt_dat = {24'h000000, acc_ff};
                  if (wb_we_i) begin
                     merged  = cisx_merge({24'h000000, acc_ff}, wb_dat_i, wb_sel_i);
                     nxt_acc = merged[7:0];
                  end
               end
               `CISX_ADR_PC: begin
                  nxt_dat = {19'h00000, pc_ff};
                  if (wb_we_i) begin
                     merged = cisx_merge({19'h00000, pc_ff}, wb_dat_i, wb_sel_i);
                     nxt_pc = merged[12:0];
                  end
               end
               `CISX_ADR_LATCH: begin
                  nxt_dat = {27'h0000000, latch_ff};
                  if (wb_we_i) begin
                     merged    = cisx_merge({27'h0000000, latch_ff}, wb_dat_i, wb_sel_i);
                     nxt_latch = merged[4:0];
                  end
               end
               `CISX_ADR_STACK: begin
                  nxt_dat = stack_rd;
               end
               default: begin
                  nxt_dat = 32'h00000000;
               end
            endcase
         end
      end

      // instruction execution
      case (state_ff)
         S_IDLE: begin
         end
         S_EXEC: begin
            nxt_state = S_IDLE;
            nxt_pc    = pc_ff + 13'h0001;
            case (op)
               `CISX_OP_JUMP: begin
                  push      = 1'b1;
                  nxt_top   = pc_ff + 13'h0001;
                  nxt_sp    = sp_ff + 3'h1;
                  nxt_pc    = pc_ff;
                  nxt_state = S_JUMP2;
               end
               `CISX_OP_KICK: begin
                  nxt_wdt_clr               = 1'b1;
                  nxt_presc_clr             = 1'b1;
                  nxt_status[`CISX_ST_EXPIRY] = 1'b1;
                  nxt_status[`CISX_ST_SLEEP]  = 1'b1;
               end
               `CISX_OP_INVERT: begin
                  nxt_status[`CISX_ST_ZERO] = res_zero;
                  if (dest) begin
                     f_we    = 1'b1;
                     f_wdata = result;
                  end else begin
                     nxt_acc = result;
                  end
               end
               `CISX_OP_ZERO_F: begin
                  f_we    = 1'b1;
                  f_wdata = result;
                  nxt_status[`CISX_ST_ZERO] = 1'b1;
               end
               `CISX_OP_MINUS: begin
                  nxt_status[`CISX_ST_ZERO] = res_zero;
                  if (dest) begin
                     f_we    = 1'b1;
                     f_wdata = result;
                  end else begin
                     nxt_acc = result;
                  end
               end
               `CISX_OP_ZERO_A: begin
                  nxt_acc = result;
                  nxt_status[`CISX_ST_ZERO] = 1'b1;
               end
               default: begin
               end
            endcase
         end
         S_JUMP2: begin
            nxt_pc    = {latch_ff[`CISX_LATCH_HI:`CISX_LATCH_LO], k_imm};
            nxt_state = S_IDLE;
         end
         default: begin
            nxt_state = S_IDLE;
         end
      endcase

      nxt_busy = (nxt_state != S_IDLE);
   end

   // return stack entries, cleared so the window never reads unknowns
   always @(posedge clk_i) begin
      if (rst_i) begin
         for (j = 0; j < 8; j = j + 1) begin
            stack_ff[j] <= `CISX_PC_RST;
         end
      end else if (push) begin
         stack_ff[sp_ff] <= nxt_top;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         state_ff     <= S_IDLE;
         instr_ff     <= `CISX_INSTR_RST;
         status_ff    <= `CISX_STATUS_RST;
         acc_ff       <= `CISX_ACC_RST;
         pc_ff        <= `CISX_PC_RST;
         latch_ff     <= `CISX_LATCH_RST;
         sp_ff        <= `CISX_SP_RST;
         top_ff       <= `CISX_PC_RST;
         dat_ff       <= 32'h00000000;
         ack_ff       <= 1'b0;
         wdt_clr_ff   <= 1'b0;
         presc_clr_ff <= 1'b0;
         busy_ff      <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         instr_ff     <= nxt_instr;
         status_ff    <= nxt_status;
         acc_ff       <= nxt_acc;
         pc_ff        <= nxt_pc;
         latch_ff     <= nxt_latch;
         sp_ff        <= nxt_sp;
         top_ff       <= nxt_top;
         dat_ff       <= nxt_dat;
         ack_ff       <= nxt_ack;
         wdt_clr_ff   <= nxt_wdt_clr;
         presc_clr_ff <= nxt_presc_clr;
         busy_ff      <= nxt_busy;
      end
   end

   assign wb_dat_o          = dat_ff;
   assign wb_ack_o          = ack_ff;
   assign pc_o              = pc_ff;
   assign acc_o             = acc_ff;
   assign status_o          = status_ff;
   assign stack_top_o       = top_ff;
   assign wdt_clear_o       = wdt_clr_ff;
   assign wdt_presc_clear_o = presc_clr_ff;
   assign busy_o            = busy_ff;

endmodule // cisx_core

// ===== rtl/cisx_map.vh
// offsets, field positions, codes and reset values of the instruction executor
// How it works
// - subroutine_jump first pushes program counter plus one onto the return stack.
// - subroutine_jump loads its 11-bit immediate into program counter bits 10..0.
// - subroutine_jump takes pc 12..11 from latch bits 4..3; two cycles total.
// - watchdog_kick resets the watchdog counter to zero.
// - watchdog_kick also clears the watchdog prescaler in the same operation.
// - watchdog_kick sets expiry and sleep-entry flags; other flags unchanged.
// - invert_file complements file register into accumulator or file; updates zero flag.
// - zero_file clears file register 0..127 and always sets the zero flag.
// - file_minus_one subtracts one from the file register and updates zero flag.
// - file_minus_one with destination 0 writes accumulator, file register untouched.
// - file_minus_one with destination 1 writes file register, accumulator untouched.
// - zero_accumulator clears accumulator, sets zero flag, touches no file register.
`ifndef CISX_MAP_VH
`define CISX_MAP_VH

// register byte offsets
`define CISX_ADR_INSTR      12'h000
`define CISX_ADR_STATUS     12'h004
`define CISX_ADR_ACC        12'h008
`define CISX_ADR_PC         12'h00C
`define CISX_ADR_LATCH      12'h010
`define CISX_ADR_STACK      12'h014
// return stack window: byte address 0x040 + 4 * entry
`define CISX_STACK_TAG      7'h02
// file registers: byte address 0x200 + 4 * index
`define CISX_FILE_TAG       3'h1

// instruction word fields
`define CISX_OP_HI          18
`define CISX_OP_LO          16
`define CISX_DEST_BIT       15
`define CISX_K_HI           10
`define CISX_F_HI           6
`define CISX_LATCH_HI       4
`define CISX_LATCH_LO       3
`define CISX_BUSY_BIT       31

// operation codes
`define CISX_OP_NONE        3'h0
`define CISX_OP_JUMP        3'h1
`define CISX_OP_KICK        3'h2
`define CISX_OP_INVERT      3'h3
`define CISX_OP_ZERO_F      3'h4
`define CISX_OP_MINUS       3'h5
`define CISX_OP_ZERO_A      3'h6

// status bit positions
`define CISX_ST_ZERO        2
`define CISX_ST_SLEEP       3
`define CISX_ST_EXPIRY      4

// reset values
`define CISX_INSTR_RST      32'h00000000
`define CISX_STATUS_RST     8'h18
`define CISX_ACC_RST        8'h00
`define CISX_PC_RST         13'h0000
`define CISX_LATCH_RST      5'h00
`define CISX_SP_RST         3'h0

`endif

// ===== rtl/cisx_regfile.v
// file register array, one write port and one asynchronous read port
`timescale 1ns/1ps
module cisx_regfile (
   input  wire       clk_i,
   input  wire       wr_en_i,
   input  wire [6:0] wr_addr_i,
   input  wire [7:0] wr_data_i,
   input  wire [6:0] rd_addr_i,
   output wire [7:0] rd_data_o
);

   reg [7:0] mem_ff [0:127];

   always @(posedge clk_i) begin
      if (wr_en_i) begin
         mem_ff[wr_addr_i] <= wr_data_i;
      end
   end

   assign rd_data_o = mem_ff[rd_addr_i];

endmodule // cisx_regfile

// ===== test/cisx_monitor.sv
// port-level assertions for the instruction executor
`timescale 1ns/1ps
module cisx_monitor (
   input wire        clk_i,
   input wire        rst_i,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [11:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire        wb_ack_o,
   input wire [12:0] pc_o,
   input wire [7:0]  acc_o,
   input wire [7:0]  status_o,
   input wire [12:0] stack_top_o,
   input wire        wdt_clear_o,
   input wire        wdt_presc_clear_o,
   input wire        busy_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire       go = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 12'h000 && !wb_ack_o && !busy_o;
   wire [2:0] op = wb_dat_i[18:16];
   reg [12:0] pc_cap_ff;
   reg [10:0] k_cap_ff;
   // operands seen when an instruction is taken
   always @(posedge clk_i) begin
      if (go) begin
         pc_cap_ff <= pc_o;
         k_cap_ff  <= wb_dat_i[10:0];
      end
   end
   a_kick_pulse: assert property (
      go && op == 3'h2 |-> ##2 wdt_clear_o) else $error("watchdog clear pulse missing");
   a_presc_pair: assert property (
      wdt_clear_o == wdt_presc_clear_o) else $error("prescaler clear not paired");
   a_kick_flags: assert property (
      wdt_clear_o |-> status_o[4:3] == 2'b11) else $error("kick flags not set");
   a_jump_push: assert property (
      go && op == 3'h1 |-> ##2 stack_top_o == pc_cap_ff + 13'h1 && pc_o == pc_cap_ff)
      else $error("return address push wrong");
   a_jump_load: assert property (
      go && op == 3'h1 |-> ##1 busy_o [*2] ##1 !busy_o && pc_o[10:0] == k_cap_ff)
      else $error("jump target or length wrong");
   a_one_cycle: assert property (
      go && op > 3'h1 |-> ##1 busy_o ##1 !busy_o && pc_o == pc_cap_ff + 13'h1)
      else $error("single cycle step wrong");
   a_zero_acc: assert property (
      go && op == 3'h6 |-> ##2 acc_o == 8'h00 && status_o[2]) else $error("acc clear wrong");
   a_zero_file: assert property (
      go && op == 3'h4 |-> ##2 status_o[2]) else $error("zero flag not set");
   a_keep_acc: assert property (
      go && (op == 3'h3 || op == 3'h5) && wb_dat_i[15] |-> ##2 acc_o == $past(acc_o, 2))
      else $error("acc changed on file destination");
endmodule // cisx_monitor

bind cisx_core cisx_monitor i_mon (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
   .pc_o(pc_o), .acc_o(acc_o), .status_o(status_o), .stack_top_o(stack_top_o),
   .wdt_clear_o(wdt_clear_o), .wdt_presc_clear_o(wdt_presc_clear_o), .busy_o(busy_o));

// ===== test/core_instruction_subset_exec_tb.sv
// self-checking bench for the instruction executor
`timescale 1ns/1ps
module core_instruction_subset_exec_tb;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [31:0] wdat = 32'h0;
   logic [31:0] q;
   logic [12:0] pcx;
   logic [42:0] rows [8];
   wire  [31:0] rdat;
   wire         ack, busy, clr, pclr;
   wire  [12:0] pc, stk;
   wire  [7:0]  acc, st;
   int          err_total = 0;
   int          compares = 0;
   int          kicks = 0;
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) if ((clr & pclr) === 1'b1) kicks++;
   cisx_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .pc_o(pc), .acc_o(acc), .status_o(st), .stack_top_o(stk),
      .wdt_clear_o(clr), .wdt_presc_clear_o(pclr), .busy_o(busy));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // one classic cycle, held until ack
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 40);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 40) begin
         err_total++;
         close_out();
      end
   endtask
   initial begin
      // op, dest, index, file in, acc out, file out, status out
      rows[0] = {3'h3, 1'b0, 7'h05, 8'hFF, 8'h00, 8'hFF, 8'h04};
      rows[1] = {3'h3, 1'b1, 7'h06, 8'h0F, 8'h5A, 8'hF0, 8'h00};
      rows[2] = {3'h4, 1'b0, 7'h7F, 8'h33, 8'h5A, 8'h00, 8'h04};
      rows[3] = {3'h5, 1'b0, 7'h00, 8'h01, 8'h00, 8'h01, 8'h04};
      rows[4] = {3'h5, 1'b1, 7'h01, 8'h00, 8'h5A, 8'hFF, 8'h00};
      rows[5] = {3'h6, 1'b0, 7'h02, 8'h77, 8'h00, 8'h77, 8'h04};
      rows[6] = {3'h2, 1'b0, 7'h03, 8'h44, 8'h5A, 8'h44, 8'h18};
      rows[7] = {3'h7, 1'b0, 7'h04, 8'h21, 8'h5A, 8'h21, 8'h00};
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rows[i]) begin
         xfer({3'h1, rows[i][38:32], 2'b00}, 1'b1, {24'h0, rows[i][31:24]});
         xfer(12'h008, 1'b1, 32'h5A);
         xfer(12'h004, 1'b1, 32'h0);
         pcx = pc;
         xfer(12'h000, 1'b1, {13'h0, rows[i][42:39], 8'h0, rows[i][38:32]});
         xfer(12'h008, 1'b0, 32'h0);
         check(q, {24'h0, rows[i][23:16]});
         xfer({3'h1, rows[i][38:32], 2'b00}, 1'b0, 32'h0);
         check(q, {24'h0, rows[i][15:8]});
         check(st, rows[i][7:0]);
         check(pc, pcx + 13'h1);
      end
      // back-to-back kicks
      xfer(12'h000, 1'b1, 32'h0002_0000);
      xfer(12'h000, 1'b1, 32'h0002_0000);
      xfer(12'h100, 1'b0, 32'h0);
      check(q, 32'h0);
      check(kicks, 32'h3);
      // mid-run reset
      @(posedge clk_i) rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check({pc, acc, st}, {13'h0, 8'h00, 8'h18});
      check({stk, busy, ack}, 32'h0);
      // jumps at the top and bottom of the immediate range
      xfer(12'h010, 1'b1, 32'h18);
      xfer(12'h00C, 1'b1, 32'h0123);
      xfer(12'h000, 1'b1, {13'h0, 3'h1, 5'h00, 11'h7FF});
      xfer(12'h100, 1'b0, 32'h0);
      check(stk, 13'h0124);
      check(pc, 13'h1FFF);
      xfer(12'h040, 1'b0, 32'h0);
      check(q, 32'h0124);
      xfer(12'h014, 1'b0, 32'h0);
      check(q, 32'h0001_0124);
      xfer(12'h010, 1'b1, 32'h08);
      xfer(12'h000, 1'b1, {13'h0, 3'h1, 16'h0000});
      xfer(12'h100, 1'b0, 32'h0);
      check(stk, 13'h0000);
      check(pc, 13'h0800);
      xfer(12'h044, 1'b0, 32'h0);
      check(q, 32'h0);
      close_out();
   end
endmodule // core_instruction_subset_exec_tb
